// file: verilog/fbrp_pkg.sv
// package of constants and carrier types for the flash burst read port
package fbrp_pkg;
    // ****************************************
    // sizes and field layout
    // ****************************************
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int WRAP_WORDS = 8;
    localparam int WRAP_BITS = 3;
    localparam int BOUNDARY_WORDS = 64;
    localparam int BOUNDARY_BITS = 6;
    localparam int FIFO_DEPTH = 32;
    localparam int WAIT_MIN = 2;
    localparam int WAIT_MAX = 7;
    localparam logic [2:0] WAIT_RESET = 3'h7;
    localparam logic CFG_EDGE_RESET = 1'h1;
    localparam logic CFG_RDY_RESET = 1'h1;
    localparam logic CFG_WRAP_RESET = 1'h0;
    localparam logic CFG_HSHK_RESET = 1'h0;
    localparam logic CFG_SYNC_RESET = 1'h1;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ = 50;
    localparam int T_ACC_NS = 70;
    localparam int ACC_CYC = (T_ACC_NS * CLK_MHZ) / 1000;
    localparam int ACC_CYCLES = (ACC_CYC < 1) ? 1 : ACC_CYC;
    localparam int T_RSTH_US = 50;
    localparam int RSTH_CYCLES = T_RSTH_US * CLK_MHZ;
    localparam logic [3:0] HSHK_EVEN_SAVE = 4'h1;

    // burst configuration carrier
    typedef struct packed {
        logic sync_mode;
        logic edge_rising;
        logic rdy_with_data;
        logic wrap8;
        logic handshake;
        logic [2:0] wait_states;
    } fbrp_cfg_t;

    // one word on the output path
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbrp_word_t;
endpackage

// file: verilog/fbrp_fifo.sv
// word fifo with valid and ready on both sides
`timescale 1ns/1ps
module fbrp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("fifo depth must be a power of two, at least 2");
        end
    end
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    logic full;
    logic empty;
    logic do_wr;
    logic do_rd;

    // one spare pointer bit tells full from empty honestly
    assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty = (wr_q == rd_q);
    assign in_ready = !full;
    assign do_wr = in_valid && !full;
    // only a presented head may be popped, or a word is lost unseen
    assign do_rd = out_ready && out_valid;

    // storage write
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= wr_q + 1'b1;
            end
            if (do_rd) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end

    // registered head word; valid drops when the head is taken and nothing follows
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_data <= '0;
            out_valid <= 1'b0;
        end else if (!out_valid || out_ready) begin
            out_valid <= !empty && !(do_rd && (rd_q + 1'b1 == wr_q));
            out_data <= do_rd ? mem_q[AW'(rd_q[AW-1:0] + 1'b1)] : mem_q[rd_q[AW-1:0]];
        end
    end
endmodule

// file: verilog/fbrp_array.sv
// small array memory holding the flash words, registered read data
`timescale 1ns/1ps
module fbrp_array #(
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);
    logic [DW-1:0] mem_q [1 << AW];

    // preload port and registered read
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
        rd_data <= mem_q[rd_addr];
    end
endmodule

// file: verilog/fbrp_port.sv
// burst read port of a parallel nor flash: address latch, wait states, ready and wrap
`timescale 1ns/1ps
// Contract
// - latch address at first clock edge or strobe rise
// - initial wait states programmable two to seven
// - extra stall cycle at 64-word boundary
// - edge bit zero falling, one rising
// - eight-word wrap runs until reset or new address
// - wrap ascends from start, continues from group base
// - ready timing one: ready with data
// - ready timing zero: ready one cycle early
// - handshake even start has shorter latency above two waits
// - async access from later of address, strobe fall
// - handshake also in clock synchronous burst
module fbrp_port
    import fbrp_pkg::*;
#(
    parameter int MEM_AW = 10,
    parameter int RSTH_CYC = fbrp_pkg::RSTH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic burst_clk,
    input wire logic chip_select_n,
    input wire logic output_enable_n,
    input wire logic address_valid_strobe_n,
    input wire logic [fbrp_pkg::ADDR_W-1:0] addr_in,
    input wire logic clock_edge_select_bit,
    input wire logic ready_timing_select_bit,
    input wire logic [2:0] wait_state_cfg,
    input wire logic wrap8_cfg,
    input wire logic handshake_cfg,
    input wire logic sync_mode_cfg,
    input wire logic cfg_write,
    input wire logic preload_wr,
    input wire logic [MEM_AW-1:0] preload_addr,
    input wire logic [fbrp_pkg::DATA_W-1:0] preload_data,
    output logic [fbrp_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic ready_out,
    output logic word_valid,
    input wire logic word_ready,
    output logic [fbrp_pkg::DATA_W-1:0] word_data,
    output logic powerup_done,
    output logic [fbrp_pkg::ADDR_W-1:0] burst_addr
);
    import fbrp_pkg::*;

    initial begin
        if (MEM_AW < 4 || MEM_AW > ADDR_W) begin
            $error("array address width out of range");
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    // next address inside a burst, wrapping in the aligned group when asked
    function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] a,
                                                    input logic wrap);
        logic [ADDR_W-1:0] r;
        r = a + 1'b1;
        if (wrap) begin
            r = {a[ADDR_W-1:WRAP_BITS], 3'(a[WRAP_BITS-1:0] + 1'b1)};
        end
        return r;
    endfunction

    // a word that sits on a 64-word boundary
    function automatic logic on_boundary(input logic [ADDR_W-1:0] a);
        return a[BOUNDARY_BITS-1:0] == '0;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    // three stages; a change counts once stages two and three agree
    logic [2:0] clk_sync_q;
    logic [2:0] avd_sync_q;
    logic [2:0] ce_sync_q;
    logic [2:0] oe_sync_q;
    logic clk_lvl_q;
    logic avd_lvl_q;
    logic ce_lvl_q;
    logic oe_lvl_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_sync_q <= 3'h0;
            avd_sync_q <= 3'h7;
            ce_sync_q <= 3'h7;
            oe_sync_q <= 3'h7;
        end else begin
            clk_sync_q <= {clk_sync_q[1:0], burst_clk};
            avd_sync_q <= {avd_sync_q[1:0], address_valid_strobe_n};
            ce_sync_q <= {ce_sync_q[1:0], chip_select_n};
            oe_sync_q <= {oe_sync_q[1:0], output_enable_n};
        end
    end

    // filtered levels
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_lvl_q <= 1'b0;
            avd_lvl_q <= 1'b1;
            ce_lvl_q <= 1'b1;
            oe_lvl_q <= 1'b1;
        end else begin
            if (clk_sync_q[1] == clk_sync_q[2]) begin
                clk_lvl_q <= clk_sync_q[2];
            end
            if (avd_sync_q[1] == avd_sync_q[2]) begin
                avd_lvl_q <= avd_sync_q[2];
            end
            if (ce_sync_q[1] == ce_sync_q[2]) begin
                ce_lvl_q <= ce_sync_q[2];
            end
            if (oe_sync_q[1] == oe_sync_q[2]) begin
                oe_lvl_q <= oe_sync_q[2];
            end
        end
    end

    // ****************************************
    // configuration and power-up hold
    // ****************************************
    fbrp_cfg_t cfg_q;
    logic [$clog2(RSTH_CYC+1)-1:0] rsth_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= '{CFG_SYNC_RESET, CFG_EDGE_RESET, CFG_RDY_RESET, CFG_WRAP_RESET,
                       CFG_HSHK_RESET, WAIT_RESET};
        end else if (cfg_write) begin
            cfg_q.sync_mode <= sync_mode_cfg;
            cfg_q.edge_rising <= clock_edge_select_bit;
            cfg_q.rdy_with_data <= ready_timing_select_bit;
            cfg_q.wrap8 <= wrap8_cfg;
            cfg_q.handshake <= handshake_cfg;
            // values below two are clamped: the core cannot answer faster
            cfg_q.wait_states <= (wait_state_cfg < 3'(WAIT_MIN)) ? 3'(WAIT_MIN)
                                 : wait_state_cfg;
        end
    end

    // the host owns the hold time; this only reports when it has elapsed
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rsth_q <= '0;
        end else if (rsth_q != ($bits(rsth_q))'(RSTH_CYC)) begin
            rsth_q <= rsth_q + 1'b1;
        end
    end
    assign powerup_done = (rsth_q == ($bits(rsth_q))'(RSTH_CYC));

    // ****************************************
    // edge detection on the host clock
    // ****************************************
    logic clk_prev_q;
    logic avd_prev_q;
    logic active_edge;
    logic avd_rise;
    logic avd_fall;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            clk_prev_q <= 1'b0;
            avd_prev_q <= 1'b1;
        end else begin
            clk_prev_q <= clk_lvl_q;
            avd_prev_q <= avd_lvl_q;
        end
    end
    assign active_edge = cfg_q.edge_rising ? (clk_lvl_q && !clk_prev_q)
                         : (!clk_lvl_q && clk_prev_q);
    assign avd_rise = avd_lvl_q && !avd_prev_q;
    assign avd_fall = !avd_lvl_q && avd_prev_q;

    // ****************************************
    // burst state machine
    // ****************************************
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ARMED = 5'h02,
        ST_WAIT = 5'h04,
        ST_BURST = 5'h08,
        ST_ASYNC = 5'h10
    } fbrp_state_t;
    fbrp_state_t state_q;
    logic [ADDR_W-1:0] addr_q;
    logic [3:0] wait_q;
    logic stall_q;
    logic [7:0] acc_q;
    logic latched;
    logic fifo_in_ready;
    logic [DATA_W-1:0] arr_data;
    logic take_word;
    logic [3:0] wait_load;
    logic stall_next;

    // address is latched by whichever comes first: strobe rise or active edge
    assign latched = (state_q == ST_ARMED) && (avd_rise || active_edge);
    // even start in handshake mode saves one cycle of initial latency when more than two waits are set
    assign wait_load = (cfg_q.handshake && !addr_in[0] && cfg_q.wait_states > 3'(WAIT_MIN))
                       ? 4'(cfg_q.wait_states) - HSHK_EVEN_SAVE
                       : 4'(cfg_q.wait_states);
    // the last wait edge already carries the first word
    assign take_word = active_edge && fifo_in_ready && (((state_q == ST_BURST) && !stall_q)
                       || ((state_q == ST_WAIT) && (wait_q <= 4'h1)));
    assign stall_next = !cfg_q.wrap8 && on_boundary(next_addr(addr_q, 1'b0));

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_IDLE;
            addr_q <= '0;
            wait_q <= 4'h0;
            stall_q <= 1'b0;
            acc_q <= 8'h00;
        end else if (ce_lvl_q) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (avd_fall) begin
                        state_q <= cfg_q.sync_mode ? ST_ARMED : ST_ASYNC;
                        acc_q <= 8'(ACC_CYCLES);
                    end
                end
                ST_ARMED: begin
                    if (latched) begin
                        addr_q <= addr_in;
                        wait_q <= wait_load;
                        stall_q <= 1'b0;
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (take_word) begin
                        state_q <= ST_BURST;
                        addr_q <= next_addr(addr_q, cfg_q.wrap8);
                        stall_q <= stall_next;
                    end else if (active_edge && wait_q > 4'h1) begin
                        wait_q <= wait_q - 1'b1;
                    end
                end
                ST_BURST: begin
                    // a fresh strobe low ends the wrap and starts a new access
                    if (avd_fall) begin
                        state_q <= ST_ARMED;
                    end else if (active_edge && stall_q) begin
                        stall_q <= 1'b0;
                    end else if (take_word) begin
                        addr_q <= next_addr(addr_q, cfg_q.wrap8);
                        stall_q <= stall_next;
                    end
                end
                ST_ASYNC: begin
                    // access counts from the later of strobe fall and stable address
                    if (avd_fall) begin
                        acc_q <= 8'(ACC_CYCLES);
                    end else if (acc_q != 8'h00) begin
                        acc_q <= acc_q - 1'b1;
                    end
                    if (avd_rise) begin
                        addr_q <= addr_in;
                        acc_q <= 8'(ACC_CYCLES);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
    assign burst_addr = addr_q;

    // ****************************************
    // array and data path
    // ****************************************
    fbrp_array #(.AW(MEM_AW), .DW(DATA_W)) u_array (
        .clk(sys_clk),
        .wr_en(preload_wr),
        .wr_addr(preload_addr),
        .wr_data(preload_data),
        .rd_addr(addr_q[MEM_AW-1:0]),
        .rd_data(arr_data)
    );

    // word per active edge, advancing once per word
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            data_out <= '0;
        end else if (take_word || (state_q == ST_ASYNC && acc_q == 8'h00)) begin
            data_out <= arr_data;
        end
    end
    assign data_oe = !ce_lvl_q && !oe_lvl_q;

    // ready moves on the active edge, with the data or one edge ahead of it;
    // a full fifo cannot be foreseen, so an early ready may promise a late word
    logic rdy_early;
    assign rdy_early = ((state_q == ST_WAIT) && (wait_q == 4'h2))
                       || ((state_q == ST_BURST) && stall_q) || (take_word && !stall_next);
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ready_out <= 1'b0;
        end else if (state_q == ST_ASYNC) begin
            ready_out <= 1'b1;
        end else if (state_q == ST_IDLE || state_q == ST_ARMED) begin
            ready_out <= 1'b0;
        end else if (active_edge && cfg_q.rdy_with_data) begin
            ready_out <= take_word;
        end else if (active_edge) begin
            ready_out <= rdy_early;
        end
    end

    // delivered words also stream to the user side; a full fifo stalls the burst
    fbrp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(sys_clk),
        .rstn(rstn),
        .in_data(arr_data),
        .in_valid(take_word),
        .in_ready(fifo_in_ready),
        .out_data(word_data),
        .out_valid(word_valid),
        .out_ready(word_ready)
    );
endmodule

// file: sim/fbrp_monitor.sv
// concurrent checks on the ports of the burst read port
`timescale 1ns/1ps
module fbrp_monitor #(
    parameter int RSTH_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic burst_clk,
    input wire logic chip_select_n,
    input wire logic address_valid_strobe_n,
    input wire logic clock_edge_select_bit,
    input wire logic ready_timing_select_bit,
    input wire logic wrap8_cfg,
    input wire logic sync_mode_cfg,
    input wire logic cfg_write,
    input wire logic [fbrp_pkg::DATA_W-1:0] data_out,
    input wire logic ready_out,
    input wire logic powerup_done,
    input wire logic [fbrp_pkg::ADDR_W-1:0] burst_addr
);
    import fbrp_pkg::*;
    logic [2:0] bc_q;
    logic sync_q, edge_q, rdy_q, wrap_q;
    logic [3:0] act_q;
    logic [4:0] quiet_q;
    int pcnt_q;
    wire act = edge_q ? (bc_q[1] & ~bc_q[2]) : (~bc_q[1] & bc_q[2]);
    wire quiet = quiet_q > 5'h09;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // *****
    // helper state
    // *****
    // mirror of the configuration, so checks know the mode without peeking inside
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {sync_q, edge_q, rdy_q, wrap_q} <= {CFG_SYNC_RESET, CFG_EDGE_RESET,
                CFG_RDY_RESET, CFG_WRAP_RESET};
        end else if (cfg_write) begin
            {sync_q, edge_q, rdy_q, wrap_q} <= {sync_mode_cfg, clock_edge_select_bit,
                ready_timing_select_bit, wrap8_cfg};
        end
    end
    // active edge finder, quiet-bus counter and power-up counter
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bc_q <= 3'h0;
            act_q <= 4'hf;
            quiet_q <= 5'h00;
            pcnt_q <= 0;
        end else begin
            bc_q <= {bc_q[1:0], burst_clk};
            act_q <= act ? 4'h0 : act_q + {3'h0, act_q != 4'hf};
            quiet_q <= (address_valid_strobe_n && !chip_select_n) ?
                quiet_q + {4'h0, quiet_q != 5'h1f} : 5'h00;
            pcnt_q <= (pcnt_q < RSTH_CYC + 2) ? pcnt_q + 1 : pcnt_q;
        end
    end
    // *****
    // properties
    // *****
    sequence s_hold4;
        $stable(data_out) [*4];
    endsequence
    property p_pwr_low;
        pcnt_q < RSTH_CYC - 1 |-> !powerup_done;
    endproperty
    a_pwr_low: assert property (p_pwr_low)
        else $error("power-up flag rose early");
    property p_pwr_high;
        pcnt_q >= RSTH_CYC + 2 |-> powerup_done;
    endproperty
    a_pwr_high: assert property (p_pwr_high)
        else $error("power-up flag late");
    // the opposite edge lands four cycles after the active one, outside this set
    property p_edge;
        $changed(burst_addr) && quiet |-> act_q inside {4'h7, 4'h0, 4'h1, 4'h2};
    endproperty
    a_edge: assert property (p_edge)
        else $error("burst address moved off the active edge");
    property p_step;
        $changed(burst_addr) && quiet |-> burst_addr == $past(burst_addr) + 22'h1 ||
            (burst_addr[2:0] == 3'h0 && (burst_addr >> 3) == ($past(burst_addr) >> 3));
    endproperty
    a_step: assert property (p_step)
        else $error("burst address step wrong");
    property p_wrap;
        wrap_q && $changed(burst_addr) && quiet |-> (burst_addr >> 3) == ($past(burst_addr) >> 3);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap left its group");
    property p_rdy_with;
        sync_q && rdy_q && $rose(ready_out) |-> ##[0:1] $changed(data_out);
    endproperty
    a_rdy_with: assert property (p_rdy_with)
        else $error("ready not with data");
    property p_rdy_early;
        sync_q && !rdy_q && $rose(ready_out) |-> s_hold4 ##[1:8] $changed(data_out);
    endproperty
    a_rdy_early: assert property (p_rdy_early)
        else $error("ready not one edge early");
    property p_async;
        !sync_q && $rose(address_valid_strobe_n) |-> s_hold4 ##[1:10] $changed(data_out);
    endproperty
    a_async: assert property (p_async)
        else $error("async access time wrong");
endmodule
bind fbrp_port fbrp_monitor #(.RSTH_CYC(RSTH_CYC)) u_fbrp_monitor (.sys_clk, .rstn,
    .burst_clk, .chip_select_n, .address_valid_strobe_n, .clock_edge_select_bit,
    .ready_timing_select_bit, .wrap8_cfg, .sync_mode_cfg, .cfg_write, .data_out,
    .ready_out, .powerup_done, .burst_addr);

// file: sim/fbrp_host_model.sv
// behavioural host memory controller driving the burst bus
`timescale 1ns/1ps
module fbrp_host_model (
    input wire logic sys_clk,
    output logic burst_clk,
    output logic chip_select_n,
    output logic output_enable_n,
    output logic address_valid_strobe_n,
    output logic [fbrp_pkg::ADDR_W-1:0] addr_in
);
    import fbrp_pkg::*;
    logic run = 1'b0;
    initial begin
        burst_clk = 1'b0;
        {chip_select_n, output_enable_n, address_valid_strobe_n} = 3'h7;
        addr_in = 22'h0;
    end
    // link clock runs only inside a frame, stops low, phase offset from sys_clk
    always begin
        wait (run);
        #77;
        if (run) begin
            burst_clk = 1'b1;
        end
        #80;
        burst_clk = 1'b0;
        #3;
    end
    // address phase: the strobe rises before any clock edge, so it does the latching
    task automatic open_burst(input logic [ADDR_W-1:0] a, input logic sync);
        @(negedge sys_clk);
        {chip_select_n, output_enable_n, address_valid_strobe_n} = 3'h0;
        addr_in = a;
        repeat (12) @(negedge sys_clk);
        address_valid_strobe_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        addr_in = ~a; // released bus shows the inverse, never the old value
        run = sync;
    endtask
    // end of frame: let the clock stop low before deselecting
    task automatic close_burst();
        run = 1'b0;
        repeat (12) @(negedge sys_clk);
        {chip_select_n, output_enable_n} = 2'h3;
        repeat (40) @(negedge sys_clk);
    endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the burst read port
`timescale 1ns/1ps
module tb;
    import fbrp_pkg::*;
    typedef struct packed {
        logic er, rdy; logic [2:0] ws; logic wr, hs;
        logic [ADDR_W-1:0] a; logic [3:0] lat, xt;
    } fbrp_row_t;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic burst_clk, chip_select_n, output_enable_n, address_valid_strobe_n;
    logic [ADDR_W-1:0] addr_in;
    logic clock_edge_select_bit = 1'b1, ready_timing_select_bit = 1'b1;
    logic wrap8_cfg = 1'b0, handshake_cfg = 1'b0, sync_mode_cfg = 1'b1, cfg_write = 1'b0;
    logic [2:0] wait_state_cfg = 3'h7;
    logic preload_wr = 1'b0, word_ready = 1'b1;
    logic [9:0] preload_addr = 10'h000;
    logic [DATA_W-1:0] preload_data = 16'h0000, data_out, word_data;
    logic data_oe, ready_out, word_valid, powerup_done;
    logic [ADDR_W-1:0] burst_addr, a0;
    int bad_count = 0, cmp_count = 0, n_edge = 0;
    logic [DATA_W-1:0] got_d[$];
    int got_e[$];
    // edge, ready timing, waits, wrap, handshake, start, first-word edge, extra
    fbrp_row_t rows [7] = '{'{1'b1, 1'b1, 3'h7, 1'b0, 1'b0, 22'h010, 4'h7, 4'h0},
        '{1'b0, 1'b0, 3'h4, 1'b0, 1'b0, 22'h021, 4'h4, 4'h0},
        '{1'b1, 1'b1, 3'h2, 1'b1, 1'b0, 22'h046, 4'h2, 4'h0},
        '{1'b1, 1'b1, 3'h6, 1'b0, 1'b1, 22'h050, 4'h5, 4'h0},
        '{1'b1, 1'b1, 3'h6, 1'b0, 1'b1, 22'h051, 4'h6, 4'h0},
        '{1'b1, 1'b0, 3'h3, 1'b1, 1'b1, 22'h0f4, 4'h2, 4'h0},
        '{1'b1, 1'b1, 3'h2, 1'b0, 1'b0, 22'h03e, 4'h2, 4'h1}};
    fbrp_port #(.MEM_AW(10), .RSTH_CYC(8)) u_fbrp_port (.*);
    fbrp_host_model u_fbrp_host_model (.sys_clk, .burst_clk, .chip_select_n,
        .output_enable_n, .address_valid_strobe_n, .addr_in);
    always #10 sys_clk = ~sys_clk;
    // count active link edges as the host sees them
    always @(burst_clk) if (burst_clk === clock_edge_select_bit) n_edge++;
    // record each word taken from the stream with the edge count at that moment
    always @(posedge sys_clk) begin
        if (word_valid === 1'b1 && word_ready === 1'b1) begin
            got_d.push_back(word_data);
            got_e.push_back(n_edge);
        end
    end
    function automatic logic [DATA_W-1:0] pat(input logic [ADDR_W-1:0] a);
        return 16'h3c00 | {6'h00, a[9:0]};
    endfunction
    function automatic logic [ADDR_W-1:0] exp_addr(input fbrp_row_t r, input int i);
        logic [ADDR_W-1:0] s;
        s = r.a + ADDR_W'(i);
        return r.wr ? {r.a[ADDR_W-1:3], s[2:0]} : s;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic set_cfg(input fbrp_row_t r, input logic sync);
        @(negedge sys_clk);
        {clock_edge_select_bit, ready_timing_select_bit, wait_state_cfg} = {r.er, r.rdy, r.ws};
        {wrap8_cfg, handshake_cfg, sync_mode_cfg, cfg_write} = {r.wr, r.hs, sync, 1'b1};
        @(negedge sys_clk);
        cfg_write = 1'b0;
    endtask
    // one burst of n words; with stall the reader holds off until the buffer refuses
    task automatic burst(input fbrp_row_t r, input int n, input logic stall);
        int k;
        got_d.delete();
        got_e.delete();
        n_edge = 0;
        k = 0;
        word_ready = !stall;
        u_fbrp_host_model.open_burst(r.a, 1'b1);
        while (stall && n_edge < 45 && k < 9000) begin
            @(negedge sys_clk);
            k++;
        end
        if (stall) begin
            a0 = burst_addr;
            repeat (16) @(negedge sys_clk);
            check(burst_addr, a0);
            word_ready = 1'b1;
            repeat (34) @(negedge sys_clk);
            check(got_d.size() inside {[32:36]}, 1);
        end
        while (got_d.size() < n && k < 9000) begin
            @(negedge sys_clk);
            k++;
        end
        u_fbrp_host_model.close_burst();
        for (int i = 0; i < n; i++) check(got_d[i], pat(exp_addr(r, i)));
        if (!stall && r.xt == 0) check(got_e[0], r.lat);
        if (!stall) check(got_e[n-1], r.lat + n - 1 + r.xt);
    endtask
    // watchdog: the whole sequence needs well under a fifth of this
    initial begin
        #1000000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        check(powerup_done, 0);
        for (int i = 0; i < 1024; i++) begin
            @(negedge sys_clk);
            {preload_wr, preload_addr, preload_data} = {1'b1, 10'(i), pat(22'(i))};
        end
        @(negedge sys_clk);
        preload_wr = 1'b0;
        check(powerup_done, 1);
        foreach (rows[i]) begin
            set_cfg(rows[i], 1'b1);
            burst(rows[i], 10, 1'b0);
        end
        set_cfg(rows[2], 1'b1);
        burst(rows[2], 40, 1'b1);
        // reset in mid burst clears the outputs and stops the wrap
        u_fbrp_host_model.open_burst(22'h0a3, 1'b1);
        repeat (60) @(negedge sys_clk);
        rstn = 1'b0;
        @(negedge sys_clk);
        check({word_valid, ready_out, powerup_done, burst_addr}, 0);
        u_fbrp_host_model.close_burst();
        rstn = 1'b1;
        repeat (12) @(negedge sys_clk);
        check(powerup_done, 1);
        // after reset the configuration is back to rising edge, seven waits, linear
        clock_edge_select_bit = 1'b1;
        burst(fbrp_row_t'{1'b1, 1'b1, 3'h7, 1'b0, 1'b0, 22'h200, 4'h7, 4'h0}, 10, 1'b0);
        // asynchronous reads, two different words
        set_cfg(rows[0], 1'b0);
        for (int i = 0; i < 2; i++) begin
            u_fbrp_host_model.open_burst(22'h155 + 22'(i * 171), 1'b0);
            // strobe rise needs the synchroniser and the access count before data stands
            repeat (4) @(negedge sys_clk);
            check(data_out, pat(22'h155 + 22'(i * 171)));
            check(data_oe, 1);
            u_fbrp_host_model.close_burst();
        end
        tally_and_finish();
    end
endmodule
